// ---- bench/shift_oneshot_master_gate_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "som_map.svh"
`define SOM_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module shift_oneshot_master_gate_tb;
   localparam logic [12:0] G = 13'h0001, FR = 13'h0002, FP = 13'h0004, FD = 13'h0008;
   localparam logic [12:0] RR = 13'h0010, RP = 13'h0020, RD = 13'h0040, LS = 13'h0080;
   localparam logic [12:0] TI = 13'h0200, CP = 13'h0800, CO = 13'h1000;
   typedef struct packed {logic [12:0] ctl; logic [3:0] bits; logic fl; logic rl;} som_row_type;
   som_row_type rows [14];
   logic aclk, aresetn, keep_bits;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic gate_enable, fwd_reset, fwd_pulse, fwd_data, rev_reset, rev_pulse, rev_data;
   logic latch_set, latch_clr, timer_in, cnt_reset, cnt_pulse, latch_out, timer_done, cnt_done;
   logic fwd_last, rev_last;
   logic [7:0] coil_in, coil_out, inverted_coil_out, os_in, os_in_region, rise_pulse, fall_pulse;
   logic [255:0] shift_bits;
   logic [15:0] hit;
   int err_count, checks_done, cycles;
   som_top #(.NBITS(256), .N_OS(8), .NCOIL(8)) i_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .keep_bits, .gate_enable,
      .fwd_reset, .fwd_pulse, .fwd_data, .rev_reset, .rev_pulse, .rev_data, .coil_in,
      .latch_set, .latch_clr, .timer_in, .cnt_reset, .cnt_pulse, .os_in, .os_in_region,
      .shift_bits, .fwd_last, .rev_last, .coil_out, .inverted_coil_out, .latch_out,
      .timer_done, .cnt_done, .rise_pulse, .fall_pulse);
   som_prog_model i_prog (
      .aclk, .gate_enable, .fwd_reset, .fwd_pulse, .fwd_data, .rev_reset, .rev_pulse,
      .rev_data, .coil_in, .latch_set, .latch_clr, .timer_in, .cnt_reset, .cnt_pulse, .os_in);
   // Clock at 40 ns period
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         print_verdict();
      end
   end
   // Write: address and data together, response awaited
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read one word
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Collect any one-shot activity over n cycles
   task automatic watch(input int n);
      hit = '0;
      repeat (n) begin
         @(posedge aclk);
         hit = hit | {fall_pulse, rise_pulse};
      end
   endtask
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {aresetn, keep_bits, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      os_in_region = 8'h0F;
      rows = '{'{G | FR, 4'h0, 1'b0, 1'b0}, '{G | FP | FD, 4'h1, 1'b0, 1'b1},
         '{G | FP | FD, 4'h1, 1'b0, 1'b1}, '{G, 4'h1, 1'b0, 1'b1},
         '{G | FP, 4'h2, 1'b0, 1'b0}, '{G, 4'h2, 1'b0, 1'b0},
         '{G | FP | FD, 4'h5, 1'b0, 1'b1}, '{G, 4'h5, 1'b0, 1'b1},
         '{G | FP, 4'hA, 1'b1, 1'b0}, '{G | RP | RD, 4'hD, 1'b1, 1'b1},
         '{G, 4'hD, 1'b1, 1'b1}, '{FP | FD, 4'hD, 1'b0, 1'b0},
         '{G | FP | FD, 4'hB, 1'b1, 1'b1}, '{G | RR, 4'h0, 1'b0, 1'b0}};
      // Input already on through reset
      i_prog.drive(G, 8'h11);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      watch(20);
      `SOM_CHK(hit[0], 1'b0)
      axi_rd(`SOM_OFS_CTRL);
      `SOM_CHK(rd, 32'h0000_0007)
      axi_rd(8'h30);
      `SOM_CHK(rsp, `SOM_RESP_SLVERR)
      // Shift table, each row held two scans
      for (int i = 0; i < 14; i++) begin
         i_prog.drive(rows[i].ctl, 8'h11);
         repeat (8) @(posedge aclk);
         `SOM_CHK({shift_bits[3:0], fwd_last, rev_last}, {rows[i].bits, rows[i].fl, rows[i].rl})
      end
      // One-shots around the region
      i_prog.drive(G, 8'h00);
      watch(12);
      `SOM_CHK(hit[8], 1'b1)
      i_prog.drive(G, 8'h11);
      watch(12);
      `SOM_CHK(hit[0], 1'b1)
      i_prog.drive(13'h0000, 8'h11);
      watch(12);
      `SOM_CHK(hit[8], 1'b0)
      i_prog.drive(13'h0000, 8'h00);
      watch(12);
      i_prog.drive(13'h0000, 8'h11);
      watch(12);
      `SOM_CHK({hit[4], hit[0]}, 2'b10)
      // Coils, latch, timer and counter open then closed
      axi_wr(`SOM_OFS_CNT_PRE, 32'h0000_0002);
      `SOM_CHK(rsp, `SOM_RESP_OKAY)
      i_prog.drive(G | CO | LS | TI, 8'h00);
      repeat (60) @(posedge aclk);
      `SOM_CHK({coil_out, inverted_coil_out, latch_out, timer_done}, {8'h5A, 8'hA5, 2'h3})
      for (int k = 0; k < 3; k++) begin
         i_prog.drive(k == 1 ? G | CO | TI : G | CO | TI | CP, 8'h00);
         repeat (8) @(posedge aclk);
      end
      `SOM_CHK(cnt_done, 1'b1)
      i_prog.drive(CO | TI | CP, 8'h00);
      repeat (8) @(posedge aclk);
      `SOM_CHK({coil_out, inverted_coil_out, latch_out, timer_done, cnt_done}, {8'h00, 8'hFF, 3'h4})
      axi_rd(`SOM_OFS_TMR_VAL);
      `SOM_CHK(rd, 32'h0000_0000)
      axi_rd(`SOM_OFS_CNT_VAL);
      `SOM_CHK(rd, 32'h0000_0002)
      // Single bit set, read back, clear
      axi_wr(`SOM_OFS_BIT, 32'h0000_0109);
      `SOM_CHK(shift_bits[9], 1'b1)
      axi_rd(`SOM_OFS_BIT);
      `SOM_CHK(rd[16], 1'b1)
      axi_wr(`SOM_OFS_BIT, 32'h0000_0209);
      `SOM_CHK(shift_bits[9], 1'b0)
      axi_wr(`SOM_OFS_BIT, 32'h0000_0109);
      // Retention strap through reset, then plain reset
      keep_bits <= 1'b1;
      do_reset();
      `SOM_CHK(shift_bits[9], 1'b1)
      keep_bits <= 1'b0;
      do_reset();
      `SOM_CHK(shift_bits, 256'h0)
      print_verdict();
   end
endmodule // shift_oneshot_master_gate_tb
`default_nettype wire

// ---- bench/som_prog_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module som_prog_model (
   input wire logic aclk,
   output logic gate_enable,
   output logic fwd_reset,
   output logic fwd_pulse,
   output logic fwd_data,
   output logic rev_reset,
   output logic rev_pulse,
   output logic rev_data,
   output logic [7:0] coil_in,
   output logic latch_set,
   output logic latch_clr,
   output logic timer_in,
   output logic cnt_reset,
   output logic cnt_pulse,
   output logic [7:0] os_in
);
   // All ladder conditions start off
   initial begin
      {gate_enable, fwd_reset, fwd_pulse, fwd_data, rev_reset, rev_pulse, rev_data} = '0;
      {latch_set, latch_clr, timer_in, cnt_reset, cnt_pulse} = '0;
      coil_in = 8'h00;
      os_in = 8'h00;
   end
   task automatic drive(input logic [12:0] c, input logic [7:0] o);
      @(posedge aclk);
      {cnt_pulse, cnt_reset, timer_in, latch_clr, latch_set} <= c[11:7];
      {rev_data, rev_pulse, rev_reset, fwd_data, fwd_pulse, fwd_reset, gate_enable} <= c[6:0];
      coil_in <= c[12] ? 8'h5A : 8'h00;
      os_in <= o;
   endtask
endmodule // som_prog_model
`default_nettype wire

// ---- bench/som_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module som_top_sva #(
   parameter int NBITS = 256,
   parameter int N_OS = 3072,
   parameter int NCOIL = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic gate_enable,
   input wire logic fwd_reset,
   input wire logic rev_pulse,
   input wire logic [N_OS-1:0] os_in,
   input wire logic [N_OS-1:0] os_in_region,
   input wire logic [NBITS-1:0] shift_bits,
   input wire logic fwd_last,
   input wire logic rev_last,
   input wire logic [NCOIL-1:0] coil_out,
   input wire logic [NCOIL-1:0] inverted_coil_out,
   input wire logic timer_done,
   input wire logic cnt_done,
   input wire logic [N_OS-1:0] rise_pulse,
   input wire logic [N_OS-1:0] fall_pulse
);
   // Single clock domain, reset aborts every attempt
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rise_one_scan: assert property (
      $rose(rise_pulse[0]) |-> rise_pulse[0] [*4] ##1 !rise_pulse[0])
      else $error("rise pulse width wrong");
   a_fall_one_scan: assert property (
      $rose(fall_pulse[0]) |-> fall_pulse[0] [*4] ##1 !fall_pulse[0])
      else $error("fall pulse width wrong");
   a_rise_cause: assert property (
      $rose(rise_pulse[0]) && os_in_region[0] |-> $past(gate_enable) && $past(os_in[0]))
      else $error("rise pulse without open input");
   a_fall_cause: assert property (
      $rose(fall_pulse[0]) && os_in_region[0] |-> $past(gate_enable) && !$past(os_in[0]))
      else $error("fall pulse from closed region");
   a_coil_closed: assert property (
      !gate_enable [*5] |-> coil_out == '0 && inverted_coil_out == '1)
      else $error("coils not forced in closed region");
   a_flags_closed: assert property (
      !gate_enable [*5] |-> !fwd_last && !rev_last && !timer_done && !cnt_done)
      else $error("flag high in closed region");
   a_reset_clears: assert property (
      (fwd_reset && gate_enable && !rev_pulse) [*5] |-> shift_bits[3:0] == 4'h0)
      else $error("shifter reset left bits set");
   // Read answered one edge after address taken
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   // Main scenarios reached
   c_rise: cover property ($rose(rise_pulse[0]));
   c_fall: cover property ($rose(fall_pulse[0]));
   c_close_on: cover property ($fell(gate_enable) && os_in[0]);
endmodule // som_top_sva
bind som_top som_top_sva #(.NBITS(NBITS), .N_OS(N_OS), .NCOIL(NCOIL)) i_sva (
   .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .gate_enable,
   .fwd_reset, .rev_pulse, .os_in, .os_in_region, .shift_bits, .fwd_last, .rev_last,
   .coil_out, .inverted_coil_out, .timer_done, .cnt_done, .rise_pulse, .fall_pulse);
`default_nettype wire

// ---- src/som_edge.sv ----
`timescale 1ns/1ns
`default_nettype none
module som_edge import som_pkg::*; #(
   parameter int N = 3072
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic scan_tick,
   input wire logic [N-1:0] sig_in,
   input wire logic [N-1:0] gate_ok,
   output logic [N-1:0] rise_pulse,
   output logic [N-1:0] fall_pulse
);
   typedef struct packed {
      logic primed;
      logic [N-1:0] prev;
      logic [N-1:0] rise;
      logic [N-1:0] fall;
   } som_edge_state_type;

   som_edge_state_type state_reg, state_next;
   logic [N-1:0] eff;

   // Region gating forces the seen input off
   assign eff = sig_in & gate_ok;

   // Per-scan edge compare, pulses stand for one scan
   always_comb begin
      state_next = state_reg;
      if (scan_tick) begin
         state_next.primed = 1'b1;
         state_next.prev = eff;
         state_next.rise = state_reg.primed ? (eff & ~state_reg.prev) : '0;
         state_next.fall = state_reg.primed ? (~eff & state_reg.prev & gate_ok) : '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rise_pulse = state_reg.rise;
   assign fall_pulse = state_reg.fall;
endmodule // som_edge
`default_nettype wire

// ---- src/som_map.svh ----
`ifndef SOM_MAP_SVH
`define SOM_MAP_SVH
// Register byte offsets on the AXI4-Lite slave
`define SOM_OFS_CTRL 8'h00
`define SOM_OFS_FWD 8'h04
`define SOM_OFS_REV 8'h08
`define SOM_OFS_DIV 8'h0C
`define SOM_OFS_BIT 8'h10
`define SOM_OFS_STATUS 8'h14
`define SOM_OFS_TMR_PRE 8'h18
`define SOM_OFS_TMR_VAL 8'h1C
`define SOM_OFS_CNT_PRE 8'h20
`define SOM_OFS_CNT_VAL 8'h24
// Control bits
`define SOM_CTRL_FWD_EN 0
`define SOM_CTRL_REV_EN 1
`define SOM_CTRL_SH_GATED 2
// Range register fields
`define SOM_BASE_LSB 0
`define SOM_LEN_LSB 16
// Bit command register fields
`define SOM_BIT_SET 8
`define SOM_BIT_CLR 9
`define SOM_BIT_VAL 16
// Status bits
`define SOM_ST_FWD_LAST 0
`define SOM_ST_REV_LAST 1
`define SOM_ST_TMR_DONE 2
`define SOM_ST_CNT_DONE 3
`define SOM_ST_GATE 4
`define SOM_ST_LATCH 5
// Reset values
`define SOM_CTRL_RST 4'h7
`define SOM_RANGE_LEN_RST 9'h004
`define SOM_SCAN_DIV_RST 16'h0003
`define SOM_TMR_PRE_RST 16'h000A
`define SOM_CNT_PRE_RST 16'h000A
// Limits and bus answers
`define SOM_MAX_ONESHOTS 3072
`define SOM_RESP_OKAY 2'h0
`define SOM_RESP_SLVERR 2'h2
`endif

// ---- src/som_pkg.sv ----
package som_pkg;
   // One shifter's contiguous slice of the bit array
   typedef struct packed {
      logic [7:0] base;
      logic [8:0] len;
   } som_range_type;

   // Byte-lane merge of a bus write into an old word
   function automatic logic [31:0] som_merge(input logic [31:0] old_word,
         input logic [31:0] new_word, input logic [3:0] strb);
      logic [31:0] res;
      res = old_word;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = new_word[b*8 +: 8];
         end
      end
      return res;
   endfunction
endpackage

// ---- src/som_top.sv ----
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "som_map.svh"
module som_top import som_pkg::*; #(
   parameter int NBITS = 256,
   parameter int N_OS = 3072,
   parameter int NCOIL = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic keep_bits,
   input wire logic gate_enable,
   input wire logic fwd_reset,
   input wire logic fwd_pulse,
   input wire logic fwd_data,
   input wire logic rev_reset,
   input wire logic rev_pulse,
   input wire logic rev_data,
   input wire logic [NCOIL-1:0] coil_in,
   input wire logic latch_set,
   input wire logic latch_clr,
   input wire logic timer_in,
   input wire logic cnt_reset,
   input wire logic cnt_pulse,
   input wire logic [N_OS-1:0] os_in,
   input wire logic [N_OS-1:0] os_in_region,
   output logic [NBITS-1:0] shift_bits,
   output logic fwd_last,
   output logic rev_last,
   output logic [NCOIL-1:0] coil_out,
   output logic [NCOIL-1:0] inverted_coil_out,
   output logic latch_out,
   output logic timer_done,
   output logic cnt_done,
   output logic [N_OS-1:0] rise_pulse,
   output logic [N_OS-1:0] fall_pulse
);
   // Refuse sizes the logic cannot serve
   // two array variants
   if (!(NBITS == 128 || NBITS == 256)) begin : g_bad_nbits
      $error("som_top: NBITS must be 128 or 256");
   end
   if (N_OS < 1 || N_OS > `SOM_MAX_ONESHOTS) begin : g_bad_nos
      $error("som_top: N_OS out of range");
   end
   if (NCOIL < 1 || NCOIL > 32) begin : g_bad_ncoil
      $error("som_top: NCOIL must be 1 to 32");
   end

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_ok;
      logic w_ok;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [3:0] ctrl;
      som_range_type fwd;
      som_range_type rev;
      logic [15:0] div;
      logic [15:0] div_cnt;
      logic tick;
      logic [7:0] sel;
      logic [15:0] tmr_pre;
      logic [15:0] tmr_val;
      logic [15:0] cnt_pre;
      logic [15:0] cnt_val;
      logic [NBITS-1:0] bits;
      logic fwd_prev;
      logic rev_prev;
      logic cnt_prev;
      logic fwd_last;
      logic rev_last;
      logic tmr_done;
      logic cnt_done;
      logic latch;
      logic gate_seen;
      logic [NCOIL-1:0] coil;
      logic [NCOIL-1:0] icoil;
   } som_state_type;

   som_state_type state_reg, state_next;
   logic [N_OS-1:0] os_gate_ok;

   // Read mux for one register address
   function automatic logic [31:0] som_read(input som_state_type s, input logic [7:0] a);
      logic [31:0] v;
      v = '0;
      unique case (a)
         `SOM_OFS_CTRL: v[3:0] = s.ctrl;
         `SOM_OFS_FWD: v = {7'h00, s.fwd.len, 8'h00, s.fwd.base};
         `SOM_OFS_REV: v = {7'h00, s.rev.len, 8'h00, s.rev.base};
         `SOM_OFS_DIV: v[15:0] = s.div;
         `SOM_OFS_BIT: begin
            v[7:0] = s.sel;
            if (int'(s.sel) < NBITS) begin
               v[`SOM_BIT_VAL] = s.bits[s.sel];
            end
         end
         `SOM_OFS_STATUS: v[5:0] = {s.latch, s.gate_seen, s.cnt_done, s.tmr_done,
               s.rev_last, s.fwd_last};
         `SOM_OFS_TMR_PRE: v[15:0] = s.tmr_pre;
         `SOM_OFS_TMR_VAL: v[15:0] = s.tmr_val;
         `SOM_OFS_CNT_PRE: v[15:0] = s.cnt_pre;
         `SOM_OFS_CNT_VAL: v[15:0] = s.cnt_val;
         default: v = '0;
      endcase
      return v;
   endfunction

   // Known address test for the bus answer
   function automatic logic som_mapped(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= `SOM_OFS_CNT_VAL);
   endfunction

   // Whole next-state computation: bus slave, scan divider, scan logic
   always_comb begin
      logic [NBITS-1:0] b1;
      logic [NBITS-1:0] b2;
      logic [31:0] m;
      logic sh_gate;
      logic fwd_ok;
      logic rev_ok;
      logic f_rst;
      logic f_pul;
      logic f_dat;
      logic r_rst;
      logic r_pul;
      logic r_dat;
      logic t_in;
      logic c_rst;
      logic c_pul;
      int fb;
      int fe;
      int rb;
      int re;
      b1 = '0;
      b2 = '0;
      m = '0;
      state_next = state_reg;
      fb = int'(state_reg.fwd.base);
      fe = fb + int'(state_reg.fwd.len) - 1;
      rb = int'(state_reg.rev.base);
      re = rb + int'(state_reg.rev.len) - 1;
      fwd_ok = state_reg.ctrl[`SOM_CTRL_FWD_EN] && (state_reg.fwd.len != 9'h000) && (fe < NBITS);
      rev_ok = state_reg.ctrl[`SOM_CTRL_REV_EN] && (state_reg.rev.len != 9'h000) && (re < NBITS);
      sh_gate = gate_enable || !state_reg.ctrl[`SOM_CTRL_SH_GATED];
      f_rst = fwd_reset & sh_gate;
      f_pul = fwd_pulse & sh_gate;
      f_dat = fwd_data & sh_gate;
      r_rst = rev_reset & sh_gate;
      r_pul = rev_pulse & sh_gate;
      r_dat = rev_data & sh_gate;
      t_in = timer_in & gate_enable;
      c_rst = cnt_reset & gate_enable;
      c_pul = cnt_pulse & gate_enable;

      // Scan rate divider
      state_next.tick = 1'b0;
      if (state_reg.div_cnt == 16'h0000) begin
         state_next.tick = 1'b1;
         state_next.div_cnt = state_reg.div;
      end else begin
         state_next.div_cnt = state_reg.div_cnt - 16'h0001;
      end

      // One scan of shifter, timer, counter and coil logic
      if (state_reg.tick) begin
         state_next.gate_seen = gate_enable;
         b1 = state_reg.bits;
         // Forward shifter runs first, reverse sees its result
         for (int i = 0; i < NBITS; i++) begin
            if (fwd_ok && i >= fb && i <= fe) begin
               if (f_rst) begin
                  b1[i] = 1'b0;
               end else if (f_pul && !state_reg.fwd_prev) begin
                  b1[i] = (i == fb) ? f_dat : state_reg.bits[i-1];
               end
            end
         end
         b2 = b1;
         // reverse may share the forward range
         for (int i = 0; i < NBITS; i++) begin
            if (rev_ok && i >= rb && i <= re) begin
               if (r_rst) begin
                  b2[i] = 1'b0;
               end else if (r_pul && !state_reg.rev_prev) begin
                  b2[i] = (i == re) ? r_dat : b1[i+1];
               end
            end
         end
         state_next.bits = b2;
         state_next.fwd_prev = f_pul;
         state_next.rev_prev = r_pul;
         state_next.fwd_last = sh_gate && fwd_ok && b2[fe];
         state_next.rev_last = sh_gate && rev_ok && b2[rb];
         if (t_in) begin
            if (state_reg.tmr_val < state_reg.tmr_pre) begin
               state_next.tmr_val = state_reg.tmr_val + 16'h0001;
            end
            state_next.tmr_done = (state_reg.tmr_val + 16'h0001) >= state_reg.tmr_pre;
         end else begin
            state_next.tmr_val = 16'h0000;
            state_next.tmr_done = 1'b0;
         end
         if (c_rst) begin
            state_next.cnt_val = 16'h0000;
         end else if (c_pul && !state_reg.cnt_prev && state_reg.cnt_val < state_reg.cnt_pre) begin
            state_next.cnt_val = state_reg.cnt_val + 16'h0001;
         end
         state_next.cnt_prev = c_pul;
         state_next.cnt_done = gate_enable && (state_next.cnt_val >= state_reg.cnt_pre);
         // closed region: coils off, inverted on, latch holds
         state_next.coil = coil_in & {NCOIL{gate_enable}};
         state_next.icoil = ~(coil_in & {NCOIL{gate_enable}});
         if (latch_clr && gate_enable) begin
            state_next.latch = 1'b0;
         end else if (latch_set && gate_enable) begin
            state_next.latch = 1'b1;
         end
      end

      // Write response handshake
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end
      // Capture address and data in either order
      if (s_axi_awvalid && state_reg.awready) begin
         state_next.aw_ok = 1'b1;
         state_next.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_reg.wready) begin
         state_next.w_ok = 1'b1;
         state_next.wdata = s_axi_wdata;
         state_next.wstrb = s_axi_wstrb;
      end
      // Perform the write once both halves are held
      if (state_reg.aw_ok && state_reg.w_ok) begin
         state_next.aw_ok = 1'b0;
         state_next.w_ok = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = som_mapped(state_reg.waddr) ? `SOM_RESP_OKAY : `SOM_RESP_SLVERR;
         m = som_merge(som_read(state_reg, state_reg.waddr), state_reg.wdata, state_reg.wstrb);
         unique case (state_reg.waddr)
            `SOM_OFS_CTRL: state_next.ctrl = m[3:0];
            `SOM_OFS_FWD: state_next.fwd = '{base: m[7:0], len: m[24:16]};
            `SOM_OFS_REV: state_next.rev = '{base: m[7:0], len: m[24:16]};
            `SOM_OFS_DIV: state_next.div = m[15:0];
            `SOM_OFS_BIT: begin
               state_next.sel = m[7:0];
               // forced set or clear of one bit
               if (int'(m[7:0]) < NBITS && state_reg.wstrb[1]) begin
                  if (m[`SOM_BIT_SET]) begin
                     state_next.bits[m[7:0]] = 1'b1;
                  end else if (m[`SOM_BIT_CLR]) begin
                     state_next.bits[m[7:0]] = 1'b0;
                  end
               end
            end
            `SOM_OFS_TMR_PRE: state_next.tmr_pre = m[15:0];
            `SOM_OFS_CNT_PRE: state_next.cnt_pre = m[15:0];
            default: state_next.ctrl = state_reg.ctrl;
         endcase
      end
      state_next.awready = !state_next.aw_ok && !state_next.bvalid;
      state_next.wready = !state_next.w_ok && !state_next.bvalid;

      // Read channel: answer the cycle after the address is taken
      if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_reg.arready) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = som_read(state_reg, s_axi_araddr);
         state_next.rresp = som_mapped(s_axi_araddr) ? `SOM_RESP_OKAY : `SOM_RESP_SLVERR;
      end
      state_next.arready = !state_next.rvalid;
   end

   // State register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         state_reg.ctrl <= `SOM_CTRL_RST;
         state_reg.fwd <= '{base: 8'h00, len: `SOM_RANGE_LEN_RST};
         state_reg.rev <= '{base: 8'h00, len: `SOM_RANGE_LEN_RST};
         state_reg.div <= `SOM_SCAN_DIV_RST;
         state_reg.div_cnt <= `SOM_SCAN_DIV_RST;
         state_reg.tmr_pre <= `SOM_TMR_PRE_RST;
         state_reg.cnt_pre <= `SOM_CNT_PRE_RST;
         state_reg.icoil <= '1;
         state_reg.bits <= keep_bits ? state_reg.bits : '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Per-one-shot region gate
   assign os_gate_ok = ~os_in_region | {N_OS{gate_enable}};

   som_edge #(
      .N(N_OS)
   ) u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .scan_tick(state_reg.tick),
      .sig_in(os_in),
      .gate_ok(os_gate_ok),
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse)
   );

   // Outputs straight from the state register
   assign s_axi_awready = state_reg.awready;
   assign s_axi_wready = state_reg.wready;
   assign s_axi_bvalid = state_reg.bvalid;
   assign s_axi_bresp = state_reg.bresp;
   assign s_axi_arready = state_reg.arready;
   assign s_axi_rvalid = state_reg.rvalid;
   assign s_axi_rdata = state_reg.rdata;
   assign s_axi_rresp = state_reg.rresp;
   assign shift_bits = state_reg.bits;
   assign fwd_last = state_reg.fwd_last;
   assign rev_last = state_reg.rev_last;
   assign coil_out = state_reg.coil;
   assign inverted_coil_out = state_reg.icoil;
   assign latch_out = state_reg.latch;
   assign timer_done = state_reg.tmr_done;
   assign cnt_done = state_reg.cnt_done;
endmodule // som_top
`default_nettype wire
